// ### hdl/cpm_regs.sv
// Programmer model register set with APB access and stack engine
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module cpm_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  op_valid,
	input  wire cpm_pkg::cpm_op_t      op_code,
	input  wire logic [7:0]            op_a,
	input  wire logic [7:0]            op_b,
	input  wire logic                  op_to_idx,
	input  wire logic                  op_cout,
	input  wire logic                  pc_inc,
	input  wire logic                  pc_load,
	input  wire logic [15:0]           pc_value,
	input  wire logic [7:0]            stack_rdata,
	input  wire logic [cpm_pkg::CPM_NSRC-1:0] irq_pin,
	output logic                       op_ready,
	output logic      [7:0]            accumulator,
	output logic      [7:0]            index_reg,
	output logic      [15:0]           program_counter,
	output logic      [5:0]            stack_pointer,
	output logic      [4:0]            condition_flags_reg,
	output logic      [15:0]           stack_addr,
	output logic      [7:0]            stack_wdata,
	output logic                       stack_we,
	output logic                       stack_re,
	output logic      [cpm_pkg::CPM_NSRC-1:0] irq_take
);
	// ------------------------------------------------------------
	// Synchronised requests and pending latch
	// ------------------------------------------------------------
	logic [cpm_pkg::CPM_NSRC-1:0] irq_s1;
	logic [cpm_pkg::CPM_NSRC-1:0] irq_s2;
	logic [cpm_pkg::CPM_NSRC-1:0] irq_pend;
	logic [cpm_pkg::CPM_NSRC-1:0] irq_grant;
	logic [cpm_pkg::CPM_NSRC-1:0] next_take;
	logic                         mask_i;
	logic                         int_start;
	logic                         apb_wr;
	logic                         apb_rd;
	logic                         hit;
	logic [31:0]                  rd_mux;

	cpm_stack_if sif ();
	cpm_stack_seq u_seq (
		.pclk    (pclk),
		.presetn (presetn),
		.sif     (sif)
	);

	assign mask_i = condition_flags_reg[cpm_pkg::CPM_CCR_I];

	// Fixed priority: lowest index wins, others stay pending
	genvar g;
	generate
		for (g = 0; g < cpm_pkg::CPM_NSRC; g++) begin : g_irq
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					irq_s1[g]   <= 1'b0;
					irq_s2[g]   <= 1'b0;
					irq_pend[g] <= 1'b0;
				end else begin
					irq_s1[g] <= irq_pin[g];
					irq_s2[g] <= irq_s1[g];
					// Set wins over the grant that clears it
					irq_pend[g] <= irq_s2[g] |
						(irq_pend[g] & ~irq_grant[g]);
				end
			end
			if (g == 0) begin : g_first
				assign irq_grant[g] = int_start & irq_pend[g];
			end else begin : g_rest
				assign irq_grant[g] = int_start & irq_pend[g] &
					~(|irq_pend[g-1:0]);
			end
		end
	endgenerate

	// Interrupts start only between ops and while unmasked
	assign int_start = (|irq_pend) && !mask_i && !sif.busy &&
		!op_valid;
	assign next_take = irq_grant;

	// ------------------------------------------------------------
	// ALU flag derivation
	// ------------------------------------------------------------
	logic [8:0] add_sum;
	logic [4:0] half_sum;
	logic [8:0] sub_diff;
	logic       cin;
	logic [7:0] result;
	logic       is_add;
	logic       next_c;
	logic       upd_c;
	logic       upd_nz;
	logic       op_go;

	assign cin      = (op_code == cpm_pkg::CPM_OP_ADC) &&
		condition_flags_reg[cpm_pkg::CPM_CCR_C];
	assign add_sum  = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
	assign half_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} +
		{4'h0, cin};
	assign sub_diff = {1'b0, op_a} - {1'b0, op_b};
	assign is_add   = (op_code == cpm_pkg::CPM_OP_ADD) ||
		(op_code == cpm_pkg::CPM_OP_ADC);
	assign result   = is_add ? add_sum[7:0] :
		(op_code == cpm_pkg::CPM_OP_SUB) ? sub_diff[7:0] : op_a;
	assign next_c   = is_add ? add_sum[8] :
		(op_code == cpm_pkg::CPM_OP_SUB) ? sub_diff[8] : op_cout;
	assign upd_c    = is_add || (op_code == cpm_pkg::CPM_OP_SUB) ||
		(op_code == cpm_pkg::CPM_OP_SHIFT) ||
		(op_code == cpm_pkg::CPM_OP_BTST);
	assign upd_nz   = is_add || (op_code == cpm_pkg::CPM_OP_SUB) ||
		(op_code == cpm_pkg::CPM_OP_SHIFT) ||
		(op_code == cpm_pkg::CPM_OP_LOGIC) ||
		(op_code == cpm_pkg::CPM_OP_LOAD);
	assign op_go    = op_valid && !sif.busy;

	// ------------------------------------------------------------
	// Stack engine control
	// ------------------------------------------------------------
	logic       in_int;
	logic       push_now;
	logic       pull_now;
	logic [5:0] sp_pull;
	logic [7:0] push_byte;
	logic [2:0] idx;

	assign sif.start_push = int_start || (op_go &&
		op_code == cpm_pkg::CPM_OP_CALL);
	assign sif.start_pull = op_go && (op_code == cpm_pkg::CPM_OP_RET ||
		op_code == cpm_pkg::CPM_OP_RTI);
	assign sif.length = (int_start || op_code == cpm_pkg::CPM_OP_RTI) ?
		cpm_pkg::CPM_INT_LEN : cpm_pkg::CPM_CALL_LEN;
	assign push_now = sif.push;
	assign pull_now = sif.pull;
	assign sp_pull  = stack_pointer + 6'h1;
	// Pull order mirrors push: flags first on return from interrupt
	assign idx = pull_now ? (in_int ? 3'h4 - sif.step :
		3'h1 - sif.step) : sif.step;

	always_comb begin
		case (idx)
			3'h0:    push_byte = program_counter[7:0];
			3'h1:    push_byte = program_counter[15:8];
			3'h2:    push_byte = index_reg;
			3'h3:    push_byte = accumulator;
			3'h4:    push_byte = {3'h0, condition_flags_reg};
			default: push_byte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------
	logic [5:0] sp_addr;
	assign sp_addr = pull_now ? sp_pull : stack_pointer;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator         <= cpm_pkg::CPM_ACC_RST;
			index_reg           <= cpm_pkg::CPM_IDX_RST;
			program_counter     <= cpm_pkg::CPM_PC_RST;
			stack_pointer       <= cpm_pkg::CPM_SP_RST;
			condition_flags_reg <= cpm_pkg::CPM_CCR_RST;
			in_int              <= 1'b0;
			irq_take            <= '0;
			op_ready            <= 1'b0;
			stack_addr          <= 16'h0000;
			stack_wdata         <= 8'h00;
			stack_we            <= 1'b0;
			stack_re            <= 1'b0;
		end else begin
			irq_take    <= next_take;
			op_ready    <= op_go;
			stack_we    <= push_now;
			stack_re    <= pull_now;
			stack_wdata <= push_byte;
			stack_addr  <= {cpm_pkg::CPM_SP_HIGH, sp_addr};
			if (sif.start_push || sif.start_pull) begin
				in_int <= int_start ||
					(op_code == cpm_pkg::CPM_OP_RTI);
			end
			if (push_now) begin
				// Six-bit wrap overwrites old data silently
				stack_pointer <= stack_pointer - 6'h1;
				if (in_int && sif.step == 3'h4) begin
					condition_flags_reg[cpm_pkg::CPM_CCR_I] <= 1'b1;
				end
			end else if (pull_now) begin
				stack_pointer <= sp_pull;
				case (idx)
					3'h0:    program_counter[7:0]  <= stack_rdata;
					3'h1:    program_counter[15:8] <= stack_rdata;
					3'h2:    index_reg             <= stack_rdata;
					3'h3:    accumulator           <= stack_rdata;
					3'h4:    condition_flags_reg   <= stack_rdata[4:0];
					default: ;
				endcase
			end else if (op_go) begin
				case (op_code)
					cpm_pkg::CPM_OP_RSP:
						stack_pointer <= cpm_pkg::CPM_SP_RST;
					cpm_pkg::CPM_OP_CLI:
						condition_flags_reg[cpm_pkg::CPM_CCR_I] <= 1'b0;
					cpm_pkg::CPM_OP_SEI:
						condition_flags_reg[cpm_pkg::CPM_CCR_I] <= 1'b1;
					default: ;
				endcase
				if (upd_nz) begin
					if (op_to_idx) begin
						index_reg <= result;
					end else begin
						accumulator <= result;
					end
					condition_flags_reg[cpm_pkg::CPM_CCR_N] <= result[7];
					condition_flags_reg[cpm_pkg::CPM_CCR_Z] <=
						(result == 8'h00);
				end
				if (upd_c) begin
					condition_flags_reg[cpm_pkg::CPM_CCR_C] <= next_c;
				end
				if (is_add) begin
					condition_flags_reg[cpm_pkg::CPM_CCR_H] <= half_sum[4];
				end
			end else if (apb_wr) begin
				case (paddr)
					cpm_pkg::CPM_A_ACC: accumulator <= pwdata[7:0];
					cpm_pkg::CPM_A_IDX: index_reg <= pwdata[7:0];
					cpm_pkg::CPM_A_PC:  program_counter <= pwdata[15:0];
					cpm_pkg::CPM_A_SP:  stack_pointer <= pwdata[5:0];
					cpm_pkg::CPM_A_CCR:
						condition_flags_reg <= pwdata[4:0];
					default: ;
				endcase
			end
			// Fetch address loads or advances, held during stack push and pull steps
			if (!pull_now && !push_now) begin
				if (pc_load) begin
					program_counter <= pc_value;
				end else if (pc_inc) begin
					program_counter <= program_counter + 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// APB slave, one wait state for registered read data
	// ------------------------------------------------------------
	assign hit = (paddr == cpm_pkg::CPM_A_ACC) ||
		(paddr == cpm_pkg::CPM_A_IDX) || (paddr == cpm_pkg::CPM_A_PC) ||
		(paddr == cpm_pkg::CPM_A_SP) || (paddr == cpm_pkg::CPM_A_CCR) ||
		(paddr == cpm_pkg::CPM_A_STAT);
	// Core activity has priority; a write waits until the core is idle
	assign apb_wr = psel && penable && pwrite && !pready && hit &&
		!op_go && !push_now && !pull_now;
	assign apb_rd = psel && penable && !pready;
	assign rd_mux =
		(paddr == cpm_pkg::CPM_A_ACC) ? {24'h0, accumulator} :
		(paddr == cpm_pkg::CPM_A_IDX) ? {24'h0, index_reg} :
		(paddr == cpm_pkg::CPM_A_PC)  ? {16'h0, program_counter} :
		(paddr == cpm_pkg::CPM_A_SP)  ? {26'h0, stack_pointer} :
		(paddr == cpm_pkg::CPM_A_CCR) ? {27'h0, condition_flags_reg} :
		(paddr == cpm_pkg::CPM_A_STAT) ?
			{26'h0, sif.busy, in_int, irq_pend} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= (apb_rd && (!pwrite || !hit)) || apb_wr;
			pslverr <= apb_rd && !hit;
			prdata  <= (apb_rd && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_int_go;
		int_start;
	endsequence
	sequence s_five_push;
		stack_we [*5];
	endsequence
	sequence s_two_push;
		stack_we [*2];
	endsequence

	stack_window_a: assert property (@(posedge pclk) disable iff (!presetn)
		stack_we |-> stack_addr[15:6] == 10'h003)
		else $error("stack address outside page");
	int_five_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_int_go |-> ##2 s_five_push ##1 !stack_we)
		else $error("interrupt did not push five bytes");
	mask_after_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_int_go |-> ##6 mask_i)
		else $error("mask not set after entry");
	mask_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		mask_i |-> !int_start)
		else $error("interrupt taken while masked");
	sp_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
		push_now |=> stack_pointer == $past(stack_pointer) - 6'h1)
		else $error("pointer not decremented on push");
	rsp_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		op_go && op_code == cpm_pkg::CPM_OP_RSP && !pc_load |=>
		stack_pointer == 6'h3f)
		else $error("reset stack did not load pointer");
	zero_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		op_go && upd_nz && !push_now && !pull_now |=>
		condition_flags_reg[cpm_pkg::CPM_CCR_Z] ==
		($past(result) == 8'h00))
		else $error("zero flag wrong");
	half_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		op_go && op_code == cpm_pkg::CPM_OP_ADD |=>
		condition_flags_reg[cpm_pkg::CPM_CCR_H] ==
		($past(op_a[3:0]) + $past(op_b[3:0]) > 5'h0f))
		else $error("half carry wrong");
	pend_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_pend[0] && mask_i |=> irq_pend[0])
		else $error("pending request lost");
	call_two_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		op_go && op_code == cpm_pkg::CPM_OP_CALL |->
		##2 s_two_push ##1 !stack_we)
		else $error("call did not push two bytes");
	sp_inc_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		pull_now |=> stack_pointer == $past(stack_pointer) + 6'h1)
		else $error("pointer not incremented on pull");
	borrow_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		op_go && op_code == cpm_pkg::CPM_OP_SUB |=>
		condition_flags_reg[cpm_pkg::CPM_CCR_C] ==
		($past(op_a) < $past(op_b)))
		else $error("borrow flag wrong");
	neg_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		op_go && upd_nz |=>
		condition_flags_reg[cpm_pkg::CPM_CCR_N] == $past(result[7]))
		else $error("negative flag wrong");
endmodule

// ### hdl/cpm_pkg.sv
// Package: constants and types for the programmer model register set
// Behaviour
// - Eight-bit accumulator holds operands and results
// - Eight-bit index register forms indexed address
// - Sixteen-bit counter holds next fetch address
// - Reset or reset-stack loads pointer to 0FF
// - Decrement after push, increment before pull
// - Stack address is 0000000011 plus six bits
// - Sixty-four locations, silent wrap overwrites data
// - Call pushes two bytes, interrupt five
// - Five flag bits, each readable by software
// - Half-carry from bit three on add
// - Mask flag blocks all four maskable sources
// - Masked request held pending until unmasked
// - Negative flag follows sign of result
// - Zero flag set when result is zero
// - Carry flag tracks ALU carry or borrow
// - Carry also updated by bit-test and shifts
// - Interrupt entry stacks registers then sets mask
package cpm_pkg;
	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0]  CPM_ACC_RST   = 8'h00;
	localparam logic [7:0]  CPM_IDX_RST   = 8'h00;
	localparam logic [15:0] CPM_PC_RST    = 16'h0000;
	localparam logic [5:0]  CPM_SP_RST    = 6'h3f;
	localparam logic [9:0]  CPM_SP_HIGH   = 10'h003;
	localparam logic [4:0]  CPM_CCR_RST   = 5'h08;
	localparam int          CPM_CCR_C     = 0;
	localparam int          CPM_CCR_Z     = 1;
	localparam int          CPM_CCR_N     = 2;
	localparam int          CPM_CCR_I     = 3;
	localparam int          CPM_CCR_H     = 4;
	localparam logic [2:0]  CPM_CALL_LEN  = 3'h2;
	localparam logic [2:0]  CPM_INT_LEN   = 3'h5;
	localparam int          CPM_NSRC      = 4;

	// APB map
	localparam logic [7:0]  CPM_A_ACC     = 8'h00;
	localparam logic [7:0]  CPM_A_IDX     = 8'h04;
	localparam logic [7:0]  CPM_A_PC      = 8'h08;
	localparam logic [7:0]  CPM_A_SP      = 8'h0c;
	localparam logic [7:0]  CPM_A_CCR     = 8'h10;
	localparam logic [7:0]  CPM_A_STAT    = 8'h14;

	typedef enum logic [3:0] {
		CPM_OP_NONE,
		CPM_OP_LOAD,
		CPM_OP_ADD,
		CPM_OP_ADC,
		CPM_OP_SUB,
		CPM_OP_LOGIC,
		CPM_OP_SHIFT,
		CPM_OP_BTST,
		CPM_OP_CALL,
		CPM_OP_RET,
		CPM_OP_INT,
		CPM_OP_RTI,
		CPM_OP_RSP,
		CPM_OP_CLI,
		CPM_OP_SEI
	} cpm_op_t;
endpackage

// ### hdl/cpm_stack_if.sv
// Interface: stack sequencer link between register file and engine
`timescale 1ns/1ps
interface cpm_stack_if;
	logic       start_push;
	logic       start_pull;
	logic [2:0] length;
	logic       busy;
	logic       push;
	logic       pull;
	logic [2:0] step;
	modport ctrl (output start_push, start_pull, length,
		input busy, push, pull, step);
	modport seq  (input start_push, start_pull, length,
		output busy, push, pull, step);
endinterface

// ### hdl/cpm_stack_seq.sv
// Stack sequencer: steps through multi-byte push and pull bursts
`timescale 1ns/1ps
module cpm_stack_seq (
	input  wire logic pclk,
	input  wire logic presetn,
	cpm_stack_if.seq  sif
);
	logic [2:0] left;
	logic       dir_pull;
	logic [2:0] step;

	assign sif.busy = (left != 3'h0);
	assign sif.push = sif.busy && !dir_pull;
	assign sif.pull = sif.busy && dir_pull;
	assign sif.step = step;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left     <= 3'h0;
			dir_pull <= 1'b0;
			step     <= 3'h0;
		end else if (sif.busy) begin
			left <= left - 3'h1;
			step <= step + 3'h1;
		end else if (sif.start_push || sif.start_pull) begin
			left     <= sif.length;
			dir_pull <= sif.start_pull;
			step     <= 3'h0;
		end
	end
endmodule

// ### test/cpm_core_model.sv
// Core-side stack memory model serving the register set's stack bursts
`timescale 1ns/1ps
module cpm_core_model (
	input  wire logic        pclk,
	input  wire logic [5:0]  stack_pointer,
	input  wire logic [15:0] stack_addr,
	input  wire logic [7:0]  stack_wdata,
	input  wire logic        stack_we,
	output logic      [7:0]  stack_rdata
);
	logic [7:0] mem [64];

	// Pull data must be ready before the pull step, so read above pointer
	assign stack_rdata = mem[6'(stack_pointer + 6'h01)];

	// Only six address bits select a location, so overruns overwrite
	always @(posedge pclk)
		if (stack_we)
			mem[stack_addr[5:0]] <= stack_wdata;
endmodule

// ### test/cpu_programmer_model_regs_tb.sv
// Self-checking bench for the programmer model register set
`timescale 1ns/1ps
module cpu_programmer_model_regs_tb;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0, prdata, q;
	logic             pready, pslverr, err, op_ready;
	logic             op_valid = 1'b0, op_to_idx = 1'b0, op_cout = 1'b0;
	cpm_pkg::cpm_op_t op_code = cpm_pkg::CPM_OP_NONE;
	logic [7:0]       op_a = 8'h00, op_b = 8'h00, stack_rdata;
	logic             pc_inc = 1'b0, pc_load = 1'b0;
	logic [15:0]      pc_value = 16'h0, program_counter, stack_addr;
	logic [3:0]       irq_pin = 4'h0, irq_take, took = 4'h0;
	logic [7:0]       accumulator, index_reg, stack_wdata;
	logic [5:0]       stack_pointer;
	logic [4:0]       condition_flags_reg, cc;
	logic             stack_we, stack_re;
	int               miscompares = 0;
	int               samples_checked = 0;

	cpm_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
		.op_a(op_a), .op_b(op_b), .op_to_idx(op_to_idx),
		.op_cout(op_cout), .pc_inc(pc_inc), .pc_load(pc_load),
		.pc_value(pc_value), .stack_rdata(stack_rdata),
		.irq_pin(irq_pin), .op_ready(op_ready),
		.accumulator(accumulator), .index_reg(index_reg),
		.program_counter(program_counter),
		.stack_pointer(stack_pointer),
		.condition_flags_reg(condition_flags_reg),
		.stack_addr(stack_addr), .stack_wdata(stack_wdata),
		.stack_we(stack_we), .stack_re(stack_re), .irq_take(irq_take));

	cpm_core_model u_core (.pclk(pclk), .stack_pointer(stack_pointer),
		.stack_addr(stack_addr), .stack_wdata(stack_wdata),
		.stack_we(stack_we), .stack_rdata(stack_rdata));

	always #2 pclk = ~pclk;

	always @(posedge pclk) begin
		if (irq_take !== 4'h0)
			took <= took | irq_take;
		if (stack_we === 1'b1 || stack_re === 1'b1)
			check(32'(stack_addr[15:6]), 32'h003);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never re-drives psel at once
		@(posedge pclk);
	endtask

	// Burst end is seen through the busy status bit, not a fixed wait
	task automatic idle();
		do begin
			apb(1'b0, cpm_pkg::CPM_A_STAT, 32'h0);
		end while (q[5] !== 1'b0);
	endtask

	task automatic op(input cpm_pkg::cpm_op_t c, input logic [7:0] a, b,
		input logic ci, x);
		op_valid <= 1'b1;
		op_code <= c;
		op_a <= a;
		op_b <= b;
		op_cout <= ci;
		op_to_idx <= x;
		@(posedge pclk);
		op_valid <= 1'b0;
		do begin
			@(posedge pclk);
		end while (op_ready !== 1'b1);
	endtask

	task automatic alu(input cpm_pkg::cpm_op_t c, input logic [7:0] a, b,
		input logic ci, x, input logic [8:0] r, input logic [4:0] f, m);
		op(c, a, b, ci, x);
		idle();
		if (r[8])
			check(32'(x ? index_reg : accumulator), 32'(r[7:0]));
		check(32'(condition_flags_reg & m), 32'(f & m));
	endtask

	task automatic pc_set(input logic [15:0] v);
		pc_load <= 1'b1;
		pc_value <= v;
		@(posedge pclk);
		pc_load <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic t_reset();
		check(32'(stack_pointer), 32'h3f);
		check(32'(condition_flags_reg), 32'h08);
		apb(1'b0, cpm_pkg::CPM_A_CCR, 32'h0);
		check(q & 32'h1f, 32'h08);
	endtask

	task automatic t_regs();
		apb(1'b1, cpm_pkg::CPM_A_ACC, 32'h5a);
		apb(1'b0, cpm_pkg::CPM_A_ACC, 32'h0);
		check(q & 32'hff, 32'h5a);
		apb(1'b0, 8'h18, 32'h0);
		check(32'(err), 32'h1);
		pc_set(16'h1234);
		pc_inc <= 1'b1;
		@(posedge pclk);
		pc_inc <= 1'b0;
		@(posedge pclk);
		check(32'(program_counter), 32'h1235);
	endtask

	task automatic t_alu();
		alu(cpm_pkg::CPM_OP_ADD, 8'h0f, 8'h01, 0, 0, 9'h110, 5'h18, 5'h1f);
		alu(cpm_pkg::CPM_OP_ADD, 8'h01, 8'h02, 0, 0, 9'h103, 5'h08, 5'h1f);
		alu(cpm_pkg::CPM_OP_ADD, 8'hff, 8'h01, 0, 0, 9'h100, 5'h1b, 5'h1f);
		alu(cpm_pkg::CPM_OP_ADC, 8'h7f, 8'h00, 1, 0, 9'h180, 5'h1c, 5'h1f);
		alu(cpm_pkg::CPM_OP_SUB, 8'h00, 8'h01, 0, 0, 9'h1ff, 5'h0d, 5'h0f);
		alu(cpm_pkg::CPM_OP_LOAD, 8'h80, 8'h00, 0, 1, 9'h180, 5'h04, 5'h06);
		alu(cpm_pkg::CPM_OP_LOGIC, 8'h00, 8'h00, 0, 0, 9'h100, 5'h02, 5'h06);
		alu(cpm_pkg::CPM_OP_SHIFT, 8'h81, 8'h00, 1, 0, 9'h000, 5'h01, 5'h01);
		alu(cpm_pkg::CPM_OP_SHIFT, 8'h01, 8'h00, 0, 0, 9'h000, 5'h00, 5'h01);
		alu(cpm_pkg::CPM_OP_BTST, 8'h01, 8'h00, 1, 0, 9'h000, 5'h01, 5'h01);
	endtask

	task automatic t_stack();
		pc_set(16'h2345);
		alu(cpm_pkg::CPM_OP_CALL, 8'h00, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		check(32'(stack_pointer), 32'h3d);
		check(32'({u_core.mem[6'h3e], u_core.mem[6'h3f]}), 32'h2345);
		pc_set(16'h0000);
		alu(cpm_pkg::CPM_OP_RET, 8'h00, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		check(32'({stack_pointer, program_counter}), 32'h3f2345);
		for (int i = 0; i < 33; i++)
			alu(cpm_pkg::CPM_OP_CALL, 8'h00, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		check(32'(stack_pointer), 32'h3d);
		alu(cpm_pkg::CPM_OP_RSP, 8'h00, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		check(32'(stack_pointer), 32'h3f);
		apb(1'b0, cpm_pkg::CPM_A_SP, 32'h0);
		check(q, 32'h3f);
	endtask

	task automatic t_irq();
		alu(cpm_pkg::CPM_OP_LOAD, 8'h11, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		alu(cpm_pkg::CPM_OP_LOAD, 8'h22, 8'h00, 0, 1, 9'h000, 5'h00, 5'h00);
		alu(cpm_pkg::CPM_OP_SEI, 8'h00, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		pc_set(16'h1357);
		irq_pin <= 4'h2;
		repeat (3) @(posedge pclk);
		irq_pin <= 4'h0;
		repeat (20) @(posedge pclk);
		check(32'(took), 32'h0);
		op(cpm_pkg::CPM_OP_CLI, 8'h00, 8'h00, 1'b0, 1'b0);
		cc = condition_flags_reg;
		repeat (30) @(posedge pclk);
		idle();
		check(32'(took), 32'h2);
		check(32'(stack_pointer), 32'h3a);
		check(32'({u_core.mem[6'h3f], u_core.mem[6'h3e], u_core.mem[6'h3d],
			u_core.mem[6'h3c]}), 32'h57132211);
		check(32'(u_core.mem[6'h3b]), 32'(cc));
		check(32'(condition_flags_reg[3]), 32'h1);
		pc_set(16'h0000);
		alu(cpm_pkg::CPM_OP_RTI, 8'h00, 8'h00, 0, 0, 9'h000, 5'h00, 5'h00);
		check(32'({stack_pointer, accumulator, index_reg}), 32'h3f1122);
		check(32'(program_counter), 32'h1357);
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_regs();
		t_alu();
		t_stack();
		t_irq();
		finish_test();
	end

	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
endmodule
